/* rtl/bus_memory_load_verify_sequencer.sv */
`timescale 1ns/1ps
`include "load_seq_map.svh"

// Operation
// [R1] loader commands bootstrap load after enable discrete
// [R2] bootstrap entry shown by status without error
// [R3] loader retries failed bootstrap twice more
// [R4] loader polls status while wait stays set
// [R5] bad status after bootstrap means failed entry
// [R6] good status then four-word header
// [R7] loader polls status after header and data
// [R8] loader delays status poll after trailer
// [R9] wait held during checksum, then success reported
// [R10] loader retries failed record twice, then next
// [R11] loader optionally starts execution, then verifies
// [R12] verify read answers with data from memory
// [R13] loader compares verified record locally
// [R14] loader flags no response after 12 usec
// [R15] status starts 2 to 10 usec after end
// [R16] loader leaves 8 usec before next command
// [R17] status layout: address, error, wait, success
// [R18] error flag set on fault, cleared after status
// [R19] loader retries record or bootstrap on error
// [R20] loader reads wait and success only where meaningful
// [R21] bit 3 low, bit 0 low too
// [R22] answer at terminal address 6 or 1E
// [R23] success needs checksum, count and mode
// [R24] loader clears retries and idles after abort
module bus_memory_load_verify_sequencer
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic bootEnable,
  input load_seq_pkg::rx_word_s rxIn,
  output load_seq_pkg::tx_word_s txOut,
  input wire logic txReady,
  output logic memWrEn,
  output logic [15:0] memWrData,
  output logic [15:0] memAddr,
  input wire logic [15:0] memRdData,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  load_seq_pkg::boot_mode_e mode;
  load_seq_pkg::msg_e curMsg;
  logic unitSel, msgErr, success, respBusy;
  logic [11:0] respCnt;
  logic [7:0] chkCnt;
  logic [5:0] wordsLeft, txLeft, cmdCount;
  logic [2:0] wordIdx;
  logic [15:0] calcSum, rxSum, recordsOk;
  logic [12:0] expCount, dataCount;

  // command decode
  wire [4:0] ownTa = unitSel ? `TA_SIGCOMP : `TA_STORES; // see [R22]
  wire [4:0] cmdSa = rxIn.data[9:5];
  wire [4:0] cmdWc = rxIn.data[4:0];
  wire cmdTr = rxIn.data[10];
  wire isCmdWord = rxIn.valid && rxIn.isCmd;
  wire cmdHit = isCmdWord && rxIn.data[15:11] == ownTa;
  wire isMode = cmdSa == `SA_MODE0 || cmdSa == `SA_MODE1;
  wire noDataCmd = cmdTr || isMode;
  wire dataHit = rxIn.valid && !rxIn.isCmd && wordsLeft != 6'h00;
  wire lastData = dataHit && wordsLeft == 6'h01;
  wire respStart = (cmdHit && noDataCmd) || lastData;
  wire txBusy = txOut.valid;
  // a new command on the bus drops any status still owed
  wire suppress = isCmdWord && (respBusy || txBusy);
  wire txTaken = txOut.valid && txReady;
  wire statusDone = txTaken && txOut.isStatus;
  wire waitFlag = chkCnt != 8'h00;
  wire chkLast = chkCnt == 8'h01;
  wire [5:0] wcFull = {cmdWc == 5'h00, cmdWc};
  wire sendVerify = curMsg == load_seq_pkg::MSG_VREAD
    && mode == load_seq_pkg::MODE_VERIFY;
  wire respFire = respBusy && respCnt == 12'(`RESP_CYCLES - 1);

  load_seq_pkg::msg_e cmdKind;
  assign cmdKind =
    (isMode && cmdTr && cmdWc == `MC_STATUS) ? load_seq_pkg::MSG_STATUS :
    (isMode && cmdTr && cmdWc == `MC_BOOT_LOAD) ? load_seq_pkg::MSG_BOOTLD :
    (isMode && cmdTr && cmdWc == `MC_BOOT_VFY) ? load_seq_pkg::MSG_BOOTVF :
    (!cmdTr && cmdSa == `SA_HEADER) ? load_seq_pkg::MSG_HEADER :
    (!cmdTr && cmdSa == `SA_DATA) ? load_seq_pkg::MSG_DATA :
    (!cmdTr && cmdSa == `SA_TRAILER) ? load_seq_pkg::MSG_TRAILER :
    (cmdTr && cmdSa == `SA_DATA) ? load_seq_pkg::MSG_VREAD :
    load_seq_pkg::MSG_OTHER;

  logic [15:0] statusWord;
  always_comb
  begin
    statusWord = 16'h0000; // see [R21]
    statusWord[15:11] = ownTa; // see [R17]
    statusWord[`STW_ME_BIT] = msgErr;
    statusWord[`STW_WAIT_BIT] = waitFlag;
    statusWord[`STW_OK_BIT] = success;
  end

  // message framing
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      curMsg <= load_seq_pkg::MSG_OTHER;
      wordsLeft <= 6'h00;
      wordIdx <= 3'h0;
      cmdCount <= 6'h00;
    end
    else if (ce)
    begin
      if (cmdHit)
      begin
        curMsg <= cmdKind;
        wordsLeft <= noDataCmd ? 6'h00 : wcFull;
        // the bus has moved on by the time the reply is due
        cmdCount <= wcFull;
        wordIdx <= 3'h0;
      end
      else if (isCmdWord)
        wordsLeft <= 6'h00;
      else if (dataHit)
      begin
        wordsLeft <= wordsLeft - 6'h01;
        wordIdx <= (wordIdx == 3'h7) ? wordIdx : wordIdx + 3'h1;
      end
    end
  end

  // error flag: a fault in the current message wins over the clear
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      msgErr <= 1'b0;
    else if (ce)
    begin
      if (cmdHit)
        msgErr <= rxIn.err; // see [R18]
      else if (dataHit && rxIn.err)
        msgErr <= 1'b1; // see [R18]
      else if (statusDone || suppress)
        msgErr <= 1'b0; // see [R18]
    end
  end

  // bootstrap mode entry
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      mode <= load_seq_pkg::MODE_IDLE;
    else if (ce && cmdHit && !rxIn.err)
    begin
      if (cmdKind == load_seq_pkg::MSG_BOOTLD)
        mode <= bootEnable ? load_seq_pkg::MODE_LOAD
          : load_seq_pkg::MODE_IDLE; // see [R2]
      else if (cmdKind == load_seq_pkg::MSG_BOOTVF)
        mode <= bootEnable ? load_seq_pkg::MODE_VERIFY
          : load_seq_pkg::MODE_IDLE;
    end
  end

  // record accumulation: checksum covers header words, data words and the first trailer word; the second trailer word is the sum
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      calcSum <= 16'h0000;
      rxSum <= 16'h0000;
      expCount <= 13'h0000;
      dataCount <= 13'h0000;
    end
    else if (ce && dataHit)
    begin
      if (curMsg == load_seq_pkg::MSG_HEADER)
      begin
        calcSum <= (wordIdx == 3'h0) ? rxIn.data : calcSum + rxIn.data;
        if (wordIdx == 3'h0)
        begin
          dataCount <= 13'h0000;
          // zero count means 1024 words unless no transfer
          expCount <= (rxIn.data[15:14] == 2'b00) ? 13'h0000 :
            (rxIn.data[11:0] == 12'h000) ? 13'h0400 : {1'b0, rxIn.data[11:0]};
        end
      end
      else if (curMsg == load_seq_pkg::MSG_DATA)
      begin
        calcSum <= calcSum + rxIn.data;
        dataCount <= dataCount + 13'h0001;
      end
      else if (curMsg == load_seq_pkg::MSG_TRAILER)
      begin
        if (wordIdx == 3'h0)
          calcSum <= calcSum + rxIn.data;
        else if (wordIdx == 3'h1)
          rxSum <= rxIn.data;
      end
    end
  end

  // checksum compare: wait holds until the verdict is ready
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      chkCnt <= 8'h00;
      success <= 1'b0;
      recordsOk <= 16'h0000;
    end
    else if (ce)
    begin
      if (lastData && curMsg == load_seq_pkg::MSG_TRAILER)
        chkCnt <= `CHK_CYCLES; // see [R9]
      else if (waitFlag)
        chkCnt <= chkCnt - 8'h01;
      // a verdict wins over a header arriving in the same cycle
      if (chkLast)
      begin
        success <= calcSum == rxSum && dataCount == expCount
          && mode != load_seq_pkg::MODE_IDLE; // see [R23] see [R9]
        if (calcSum == rxSum && dataCount == expCount
          && mode != load_seq_pkg::MODE_IDLE)
          recordsOk <= recordsOk + 16'h0001;
      end
      else if (cmdHit && cmdKind == load_seq_pkg::MSG_HEADER)
        success <= 1'b0;
    end
  end

  // memory writes on load, reads on verify share one address pointer
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      memWrEn <= 1'b0;
      memWrData <= 16'h0000;
      memAddr <= 16'h0000;
    end
    else if (ce)
    begin
      memWrEn <= dataHit && curMsg == load_seq_pkg::MSG_DATA
        && mode == load_seq_pkg::MODE_LOAD;
      memWrData <= rxIn.data;
      if (dataHit && curMsg == load_seq_pkg::MSG_HEADER && wordIdx == 3'h1)
        memAddr <= rxIn.data;
      else if (memWrEn)
        memAddr <= memAddr + 16'h0001;
      else if (txTaken && (txOut.isStatus ? sendVerify : txLeft != 6'h00))
        memAddr <= memAddr + 16'h0001; // see [R12]
    end
  end

  // response timer and transmit holding word
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      respBusy <= 1'b0;
      respCnt <= 12'h000;
      txOut <= '0;
      txLeft <= 6'h00;
    end
    else if (ce)
    begin
      // an addressed mode or transmit command, or the last data word of a receive, restarts the timer for its reply
      if (respStart)
      begin
        respBusy <= 1'b1;
        respCnt <= 12'h000;
      end
      else if (suppress || respFire)
        respBusy <= 1'b0;
      else if (respBusy)
        respCnt <= respCnt + 12'h001; // see [R15]
      if (suppress)
        txOut.valid <= 1'b0;
      else if (respFire)
      begin
        txOut <= {1'b1, 1'b1, statusWord}; // see [R15] see [R17]
        txLeft <= sendVerify ? cmdCount : 6'h00;
      end
      else if (txTaken && (txOut.isStatus ? sendVerify : txLeft != 6'h00))
      begin
        txOut <= {1'b1, 1'b0, memRdData}; // see [R12]
        txLeft <= txLeft - 6'h01;
      end
      else if (txTaken)
        txOut.valid <= 1'b0;
    end
  end

  // register bus slave: one wait state, answer on the second access cycle
  wire apbAccess = psel && penable && pready;
  wire selCtrl = paddr == `REG_CTRL;
  wire selState = paddr == `REG_STATE;
  wire selSum = paddr == `REG_SUM;
  wire selCount = paddr == `REG_COUNT;
  wire mapped = selCtrl || selState || selSum || selCount;
  wire [31:0] readMux =
    selCtrl ? {31'h0, unitSel} :
    selState ? {26'h0, mode, waitFlag, success, msgErr, bootEnable} :
    selSum ? {rxSum, calcSum} :
    selCount ? {16'h0, recordsOk} : 32'h0000_0000;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      unitSel <= 1'(`CTRL_RESET);
    end
    else if (ce)
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= readMux;
      if (apbAccess && pwrite && selCtrl)
        unitSel <= pwdata[`CTRL_UNIT_BIT]; // see [R22]
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [12:0] gap;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      gap <= 13'h0000;
    else if (ce)
      gap <= respStart ? 13'h0000 : (gap == 13'h1FFF ? gap : gap + 13'h0001);
  end

  chk_resp_window: assert property ( // see [R15]
    $rose(txOut.valid && txOut.isStatus)
    |-> gap >= 13'(`RESP_CYCLES - 1) && gap <= 13'(`RESP_MAX_CYCLES))
    else $error("status started outside response window");
  chk_status_layout: assert property ( // see [R17]
    txOut.valid && txOut.isStatus
    |-> txOut.data[`STW_ME_BIT] == msgErr
    && txOut.data[`STW_OK_BIT] == success)
    else $error("status word fields wrong");
  chk_status_addr: assert property (txOut.valid && txOut.isStatus // see [R22]
    |-> txOut.data[15:11] == (unitSel ? 5'h1E : 5'h06))
    else $error("status carries wrong terminal address");
  chk_bit3_low: assert property (txOut.valid && txOut.isStatus // see [R21]
    |-> !txOut.data[`STW_BIT3] && !txOut.data[0])
    else $error("status bit 3 or bit 0 set");
  chk_me_clear: assert property (ce && statusDone && !isCmdWord // see [R18]
    |=> !msgErr)
    else $error("error flag not cleared after status");
  chk_boot_entry: assert property (ce && cmdHit && !rxIn.err // see [R2]
    && cmdKind == load_seq_pkg::MSG_BOOTLD && bootEnable
    |=> mode == load_seq_pkg::MODE_LOAD)
    else $error("bootstrap load not entered");
  chk_wait_hold: assert property (ce && lastData // see [R9]
    && curMsg == load_seq_pkg::MSG_TRAILER |=> waitFlag [*8])
    else $error("wait dropped during checksum");
  chk_success_cause: assert property ($rose(success) // see [R23]
    |-> $past(calcSum) == $past(rxSum) && $past(dataCount) == $past(expCount)
    && $past(mode) != load_seq_pkg::MODE_IDLE)
    else $error("success without matching record");
  chk_verify_data: assert property (txOut.valid && !txOut.isStatus // see [R12]
    |-> mode == load_seq_pkg::MODE_VERIFY)
    else $error("data sent outside verify");
  cov_boot: cover property (mode == load_seq_pkg::MODE_IDLE
    ##1 mode == load_seq_pkg::MODE_LOAD);
  cov_record_ok: cover property ($rose(success));
  cov_verify_word: cover property (txTaken && !txOut.isStatus);
  cov_me_status: cover property (statusDone && txOut.data[`STW_ME_BIT]);
endmodule

/* rtl/load_seq_map.svh */
`ifndef LOAD_SEQ_MAP_SVH
`define LOAD_SEQ_MAP_SVH

`define CLK_NS 4
`define RESP_MIN_NS 2000
`define RESP_MAX_NS 10000
`define RESP_CYCLES ((`RESP_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define RESP_MAX_CYCLES (`RESP_MAX_NS / `CLK_NS)
`define CHK_CYCLES 8'h40

`define REG_CTRL 8'h00
`define REG_STATE 8'h04
`define REG_SUM 8'h08
`define REG_COUNT 8'h0C
`define CTRL_UNIT_BIT 0
`define CTRL_RESET 32'h0000_0000

`define TA_STORES 5'h06
`define TA_SIGCOMP 5'h1E
`define STW_ME_BIT 10
`define STW_WAIT_BIT 9
`define STW_OK_BIT 7
`define STW_BIT3 3

`define MC_STATUS 5'h02
`define MC_BOOT_LOAD 5'h11
`define MC_BOOT_VFY 5'h12
`define SA_MODE0 5'h00
`define SA_MODE1 5'h1F
`define SA_DATA 5'h01
`define SA_HEADER 5'h19
`define SA_TRAILER 5'h1A
`define HDR_WORDS 3'h4

`endif

/* rtl/load_seq_pkg.sv */
package load_seq_pkg;
  typedef enum logic [1:0] {MODE_IDLE, MODE_LOAD, MODE_VERIFY} boot_mode_e;
  typedef enum logic [2:0]
  {
    MSG_OTHER, MSG_STATUS, MSG_BOOTLD, MSG_BOOTVF,
    MSG_HEADER, MSG_DATA, MSG_TRAILER, MSG_VREAD
  } msg_e;
  typedef struct packed
  {
    logic valid;
    logic isCmd;
    logic err;
    logic [15:0] data;
  } rx_word_s;
  typedef struct packed
  {
    logic valid;
    logic isStatus;
    logic [15:0] data;
  } tx_word_s;
endpackage

/* tb/bus_loader_model.sv */
`timescale 1ns/1ps
module bus_loader_model
(
  input wire logic core_clk,
  output load_seq_pkg::rx_word_s rxIn,
  input load_seq_pkg::tx_word_s txOut,
  output logic txReady
);
  int slow = 0;
  int cyc = 0;
  int mark = 0;
  initial
  begin
    rxIn = '0;
    txReady = 1'b0;
  end
  always @(posedge core_clk)
    cyc <= cyc + 1;
  // released line carries the inverse so a stale word never looks valid
  task automatic put(input logic cmd, input logic err, input logic [15:0] d);
    @(posedge core_clk);
    rxIn <= {1'b1, cmd, err, d};
    @(posedge core_clk);
    rxIn <= {1'b0, 1'b0, 1'b0, ~d};
    mark = cyc;
  endtask
  // each word is {isStatus, data}; n counts cycles since the last word
  task automatic get(input int k, output logic [16:0] d [3], output int n);
    n = 0;
    while (txOut.valid !== 1'b1 && n < 3000)
    begin
      @(posedge core_clk);
      n = cyc - mark;
    end
    repeat (slow) @(posedge core_clk);
    txReady <= 1'b1;
    for (int i = 0; i < k; i++)
    begin
      @(posedge core_clk);
      d[i] = {txOut.isStatus, txOut.data};
    end
    txReady <= 1'b0;
    repeat (2000) @(posedge core_clk);
  endtask
endmodule

/* tb/test_bus_memory_load_verify_sequencer.sv */
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      errorCnt++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end
module test_bus_memory_load_verify_sequencer;
  logic core_clk;
  logic nrst;
  logic ce;
  logic bootEnable;
  load_seq_pkg::rx_word_s rxIn;
  load_seq_pkg::tx_word_s txOut;
  logic txReady;
  logic memWrEn;
  logic [15:0] memWrData;
  logic [15:0] memAddr;
  logic [15:0] memRdData;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] mem [512];
  logic [31:0] rd;
  logic err;
  logic [16:0] w [3];
  int n;
  int errorCnt = 0;
  int checks = 0;
  // command, four data words, expected status
  localparam logic [95:0] ROWS [9] = '{
    96'h3411_0000_0000_0000_0000_3000,
    96'h3402_0000_0000_0000_0000_3000,
    96'h3324_8002_0100_0000_0000_3000,
    96'h3022_1234_5678_0000_0000_3000,
    96'h3342_0000_E9AE_0000_0000_3080,
    96'h3402_0000_0000_0000_0000_3080,
    96'h3324_0000_0000_0000_0000_3000,
    96'h3342_0000_0001_0000_0000_3000,
    96'h3412_0000_0000_0000_0000_3000
  };
  bus_memory_load_verify_sequencer bus_memory_load_verify_sequencer_inst
  (
    .core_clk(core_clk), .nrst(nrst), .ce(ce), .bootEnable(bootEnable),
    .rxIn(rxIn), .txOut(txOut), .txReady(txReady), .memWrEn(memWrEn),
    .memWrData(memWrData), .memAddr(memAddr), .memRdData(memRdData),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  bus_loader_model loader_model_inst
  (
    .core_clk(core_clk), .rxIn(rxIn), .txOut(txOut), .txReady(txReady)
  );
  // combinational read, as the memory port expects no latency
  assign memRdData = mem[memAddr[8:0]];
  always @(posedge core_clk)
    if (memWrEn)
      mem[memAddr[8:0]] <= memWrData;
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] q, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    while (pready !== 1'b1)
      @(posedge core_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic msg(input logic [95:0] r, input int bad = 0);
    int cnt;
    cnt = r[90] ? 0 : int'(r[84:80]);
    loader_model_inst.put(1'b1, 1'b0, r[95:80]);
    for (int i = 1; i <= cnt; i++)
      loader_model_inst.put(1'b0, i == bad, r[95 - 16 * i -: 16]);
    if (r[95:80] == 16'h3342)
    begin
      apb(1'b0, 8'h04, 32'h0, rd, err);
      `CHECK("wait", 1'b1, rd[3])
    end
    loader_model_inst.get(1, w, n);
    `CHECK("status", {1'b1, r[15:0]}, w[0])
    `CHECK("gap", 1'b1, n >= 499 && n <= 2501)
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge core_clk);
    errorCnt++;
    test_done;
  end
  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    bootEnable = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0, rd, err);
      `CHECK("reset reg", i == 1 ? 32'h1 : 32'h0, rd)
    end
    apb(1'b0, 8'h10, 32'h0, rd, err);
    `CHECK("unmapped", 1'b1, err)
    note("reset");
    // a faulty bootstrap command gets the error flag and is sent again
    loader_model_inst.put(1'b1, 1'b1, 16'h3411);
    loader_model_inst.get(1, w, n);
    `CHECK("boot error", 17'h13400, w[0])
    apb(1'b0, 8'h04, 32'h0, rd, err);
    `CHECK("boot refused", 32'h1, rd)
    note("boot retry");
    for (int i = 0; i < 9; i++)
      msg(ROWS[i]);
    apb(1'b0, 8'h0C, 32'h0, rd, err);
    `CHECK("record count", 32'h1, rd)
    apb(1'b0, 8'h08, 32'h0, rd, err);
    `CHECK("record sums", 32'h0001_0000, rd)
    note("table");
    msg(ROWS[2]);
    loader_model_inst.slow = 5;
    loader_model_inst.put(1'b1, 1'b0, 16'h3422);
    loader_model_inst.get(3, w, n);
    `CHECK("verify status", 17'h13000, w[0])
    `CHECK("verify word0", 17'h01234, w[1])
    `CHECK("verify word1", 17'h05678, w[2])
    `CHECK("verify end", 1'b0, txOut.valid)
    loader_model_inst.slow = 0;
    note("verify");
    msg({ROWS[2][95:16], 16'h3400}, 1);
    // the record goes again after a status with the error flag
    msg(ROWS[2]);
    msg(ROWS[1]);
    note("error flag");
    // the second command must cancel the first pending status
    loader_model_inst.put(1'b1, 1'b0, 16'h3402);
    repeat (100) @(posedge core_clk);
    msg(ROWS[1]);
    note("suppress");
    apb(1'b1, 8'h00, 32'h1, rd, err);
    msg(96'hF402_0000_0000_0000_0000_F000);
    loader_model_inst.put(1'b1, 1'b0, 16'h3402);
    loader_model_inst.get(1, w, n);
    `CHECK("foreign address", 1'b1, n >= 3000)
    note("address");
    // a low enable freezes the response timer
    loader_model_inst.put(1'b1, 1'b0, 16'hF402);
    ce <= 1'b0;
    repeat (600) @(posedge core_clk);
    `CHECK("frozen status", 1'b0, txOut.valid)
    ce <= 1'b1;
    repeat (600) @(posedge core_clk);
    `CHECK("status held", 1'b1, txOut.valid)
    nrst <= 1'b0;
    @(posedge core_clk);
    `CHECK("held status", 1'b0, txOut.valid)
    nrst <= 1'b1;
    // the control register starts afresh after an abort
    apb(1'b0, 8'h00, 32'h0, rd, err);
    `CHECK("ctrl cleared", 32'h0, rd)
    note("mid reset");
    test_done;
  end
endmodule
